//--- src/arc_pkg.sv
/*
 File: constants shared by the converter result and DAC code register slice.
 Assumes: an 8-bit register address space and 8-bit register data.
*/
package arc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ARC_OFS_SHARED_LOW  = 8'h04;
   localparam logic [7:0] ARC_OFS_IN3_HIGH    = 8'h0A;
   localparam logic [7:0] ARC_OFS_IN4_HIGH    = 8'h0B;
   localparam logic [7:0] ARC_OFS_DAC_A_LOW   = 8'h10;
   localparam logic [7:0] ARC_OFS_DAC_A_HIGH  = 8'h11;
   localparam logic [7:0] ARC_OFS_DAC_B_LOW   = 8'h12;
   localparam logic [7:0] ARC_OFS_DAC_B_HIGH  = 8'h13;
   localparam logic [7:0] ARC_OFS_DAC_C_LOW   = 8'h14;
   localparam logic [7:0] ARC_OFS_DAC_C_HIGH  = 8'h15;
   localparam logic [7:0] ARC_OFS_DAC_D_LOW   = 8'h16;
   localparam logic [7:0] ARC_OFS_DAC_D_HIGH  = 8'h17;
   // ----------------------------------------
   // Fields, widths and reset values
   // ----------------------------------------
   localparam int         ARC_NUM_DAC         = 4;
   localparam int         ARC_RESULT_BITS     = 10;
   localparam int         ARC_DAC_BITS_DFLT   = 12;
   localparam logic [7:0] ARC_RESET_VALUE     = 8'h00;
   localparam logic [7:0] ARC_UNMAPPED_READ   = 8'h00;
   localparam int         ARC_IN3_LOW_POS     = 4;
   localparam int         ARC_IN4_LOW_POS     = 6;
endpackage : arc_pkg

//--- src/arc_dac_if.sv
/*
 File: write port of one DAC code register pair.
 Assumes: driven by the register decoder on the same clock.
*/
`timescale 1ns/1ps
interface arc_dac_if;
   logic       wr_low;
   logic       wr_high;
   logic [7:0] wdata;
   logic [7:0] code_low;
   logic [7:0] code_high;
   modport dec (output wr_low, output wr_high, output wdata,
                input code_low, input code_high);
   modport chan (input wr_low, input wr_high, input wdata,
                 output code_low, output code_high);
endinterface : arc_dac_if

//--- src/arc_dac_chan.sv
/*
 File: one DAC channel code register pair, low byte left-justified.
 Assumes: synchronous active-high reset on i_sys_clk.
*/
`timescale 1ns/1ps
module arc_dac_chan
   import arc_pkg::*;
#(
   parameter int DAC_BITS = ARC_DAC_BITS_DFLT
) (
   // Clock and reset
   input  wire logic                i_sys_clk,
   input  wire logic                i_sys_rst,
   // Register side
   arc_dac_if.chan                  bus,
   // Code word to the converter
   output logic [DAC_BITS-1:0]      o_code
);
   localparam int         LOW_BITS = DAC_BITS - 8;
   localparam logic [7:0] LOW_MASK = 8'(((1 << LOW_BITS) - 1) << (8 - LOW_BITS));

   logic [7:0] low;
   logic [7:0] high;
   logic [7:0] next_low;
   logic [7:0] next_high;

   always_comb begin
      next_low  = low;
      next_high = high;
      if (bus.wr_low) begin
         next_low = bus.wdata & LOW_MASK;
      end
      if (bus.wr_high) begin
         next_high = bus.wdata;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         low  <= ARC_RESET_VALUE;
         high <= ARC_RESET_VALUE;
      end else begin
         low  <= next_low;
         high <= next_high;
      end
   end

   assign bus.code_low  = low;
   assign bus.code_high = high;
   // Upper byte then the valid left-justified low bits
   assign o_code = {high, low[7 -: LOW_BITS]};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_low_mask;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      bus.wr_low |=> low == ($past(bus.wdata) & LOW_MASK);
   endproperty
   a_low_mask: assert property (p_low_mask)
      else $error("low code register lost masked write");

   property p_code_join;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      bus.wr_high && !bus.wr_low |=> o_code[DAC_BITS-1 -: 8] == $past(bus.wdata)
         && o_code[LOW_BITS-1:0] == $past(o_code[LOW_BITS-1:0]);
   endproperty
   a_code_join: assert property (p_code_join)
      else $error("code word not formed from high register");

   property p_reset_zero;
      @(posedge i_sys_clk) i_sys_rst |=> o_code == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("code word not zero after reset");
endmodule : arc_dac_chan

//--- src/arc_regs.sv
/*
 File: converter result and DAC code register slice.
 Assumes: a host serial engine delivers one-cycle read and write strobes
 with address; results arrive from converter logic on i_sys_clk.
*/
// Behaviour
// - 0x0A reads third input result bits 9..2
// - 0x0B reads fourth input result bits 9..2
// - DAC low registers left-justified, unused bits zero
// - High register holds top eight code bits
// - DAC pairs at 0x10 to 0x17, low even
// - All DAC registers reset to zero code
// - DAC registers read back last written value, low registers with unused bits zero
// - Channel C forms its code like others
// - Shared low-bits register 0x04 is read-only
`timescale 1ns/1ps
module arc_regs
   import arc_pkg::*;
#(
   parameter int DAC_BITS = ARC_DAC_BITS_DFLT
) (
   // Clock and reset
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_sys_rst,
   // Host register port
   input  wire logic                      i_reg_wr,
   input  wire logic                      i_reg_rd,
   input  wire logic [7:0]                i_reg_addr,
   input  wire logic [7:0]                i_reg_wdata,
   output logic      [7:0]                o_reg_rdata,
   // Conversion results
   input  wire logic                      i_result_valid,
   input  wire logic [ARC_RESULT_BITS-1:0] i_analog_input_third,
   input  wire logic [ARC_RESULT_BITS-1:0] i_analog_input_fourth,
   input  wire logic [7:0]                i_shared_low_other,
   // Code words
   output logic [DAC_BITS-1:0]            o_dac_output_a,
   output logic [DAC_BITS-1:0]            o_dac_output_b,
   output logic [DAC_BITS-1:0]            o_dac_output_c,
   output logic [DAC_BITS-1:0]            o_dac_output_d
);
   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   logic [7:0] input3_result_high;
   logic [7:0] input4_result_high;
   logic [7:0] shared_low;
   logic [7:0] next_input3_result_high;
   logic [7:0] next_input4_result_high;
   logic [7:0] next_shared_low;

   always_comb begin
      next_input3_result_high = input3_result_high;
      next_input4_result_high = input4_result_high;
      next_shared_low         = shared_low;
      // Only the converter loads these; host writes never reach them
      if (i_result_valid) begin
         next_input3_result_high = i_analog_input_third[9:2];
         next_input4_result_high = i_analog_input_fourth[9:2];
         next_shared_low = {i_analog_input_fourth[1:0], i_analog_input_third[1:0],
                            i_shared_low_other[3:0]};
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         input3_result_high <= ARC_RESET_VALUE;
         input4_result_high <= ARC_RESET_VALUE;
         shared_low         <= ARC_RESET_VALUE;
      end else begin
         input3_result_high <= next_input3_result_high;
         input4_result_high <= next_input4_result_high;
         shared_low         <= next_shared_low;
      end
   end

   // ----------------------------------------
   // DAC channels
   // ----------------------------------------
   arc_dac_if dac_port [ARC_NUM_DAC] ();
   logic [DAC_BITS-1:0] code [ARC_NUM_DAC];
   logic [7:0]          chan_low [ARC_NUM_DAC];
   logic [7:0]          chan_high [ARC_NUM_DAC];

   for (genvar g = 0; g < ARC_NUM_DAC; g++) begin : g_dac
      // Low at even offset, high at the next one
      assign dac_port[g].wr_low  = i_reg_wr &&
         i_reg_addr == ARC_OFS_DAC_A_LOW + 8'(2 * g);
      assign dac_port[g].wr_high = i_reg_wr &&
         i_reg_addr == ARC_OFS_DAC_A_HIGH + 8'(2 * g);
      assign dac_port[g].wdata   = i_reg_wdata;
      assign chan_low[g]  = dac_port[g].code_low;
      assign chan_high[g] = dac_port[g].code_high;
      arc_dac_chan #(.DAC_BITS(DAC_BITS)) u_chan (
         .i_sys_clk (i_sys_clk),
         .i_sys_rst (i_sys_rst),
         .bus       (dac_port[g]),
         .o_code    (code[g])
      );
   end

   assign o_dac_output_a = code[0];
   assign o_dac_output_b = code[1];
   assign o_dac_output_c = code[2];
   assign o_dac_output_d = code[3];

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   logic [7:0] rdata;
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = rdata;
      if (i_reg_rd) begin
         case (i_reg_addr)
            ARC_OFS_SHARED_LOW: next_rdata = shared_low;
            ARC_OFS_IN3_HIGH:   next_rdata = input3_result_high;
            ARC_OFS_IN4_HIGH:   next_rdata = input4_result_high;
            ARC_OFS_DAC_A_LOW:  next_rdata = chan_low[0];
            ARC_OFS_DAC_A_HIGH: next_rdata = chan_high[0];
            ARC_OFS_DAC_B_LOW:  next_rdata = chan_low[1];
            ARC_OFS_DAC_B_HIGH: next_rdata = chan_high[1];
            ARC_OFS_DAC_C_LOW:  next_rdata = chan_low[2];
            ARC_OFS_DAC_C_HIGH: next_rdata = chan_high[2];
            ARC_OFS_DAC_D_LOW:  next_rdata = chan_low[3];
            ARC_OFS_DAC_D_HIGH: next_rdata = chan_high[3];
            default:            next_rdata = ARC_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rdata <= ARC_RESET_VALUE;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign o_reg_rdata = rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_in3_load;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_result_valid |=> input3_result_high == $past(i_analog_input_third[9:2])
         && shared_low[5:4] == $past(i_analog_input_third[1:0]);
   endproperty
   a_in3_load: assert property (p_in3_load)
      else $error("third input result not loaded");

   property p_in4_read;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_reg_rd && i_reg_addr == ARC_OFS_IN4_HIGH |=> o_reg_rdata == $past(input4_result_high);
   endproperty
   a_in4_read: assert property (p_in4_read)
      else $error("fourth input result read wrong");

   property p_dac_c_read;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == ARC_OFS_DAC_C_HIGH ##1
      i_reg_rd && i_reg_addr == ARC_OFS_DAC_C_HIGH && !i_reg_wr
      |=> o_reg_rdata == $past(i_reg_wdata, 2);
   endproperty
   a_dac_c_read: assert property (p_dac_c_read)
      else $error("channel C high readback mismatch");

   property p_result_hold;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      !i_result_valid |=> $stable(input3_result_high) && $stable(input4_result_high)
         && $stable(shared_low);
   endproperty
   a_result_hold: assert property (p_result_hold)
      else $error("result register changed without conversion");

   property p_dac_c_code;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_dac_output_c[DAC_BITS-1 -: 8] == chan_high[2];
   endproperty
   a_dac_c_code: assert property (p_dac_c_code)
      else $error("channel C code not from its high register");

   property p_in4_load;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_result_valid |=> input4_result_high == $past(i_analog_input_fourth[9:2])
         && shared_low[ARC_IN4_LOW_POS +: 2] == $past(i_analog_input_fourth[1:0]);
   endproperty
   a_in4_load: assert property (p_in4_load)
      else $error("fourth input result not loaded");

   property p_in3_read;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_reg_rd && i_reg_addr == ARC_OFS_IN3_HIGH |=> o_reg_rdata == $past(input3_result_high);
   endproperty
   a_in3_read: assert property (p_in3_read)
      else $error("third input result read wrong");

   property p_shared_read;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_reg_rd && i_reg_addr == ARC_OFS_SHARED_LOW |=> o_reg_rdata == $past(shared_low);
   endproperty
   a_shared_read: assert property (p_shared_read)
      else $error("shared low-bits register read wrong");

   property p_rdata_hold;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");

   property p_codes_reset;
      @(posedge i_sys_clk) i_sys_rst |=> o_dac_output_a == '0 && o_dac_output_b == '0
         && o_dac_output_c == '0 && o_dac_output_d == '0;
   endproperty
   a_codes_reset: assert property (p_codes_reset)
      else $error("code words not zero after reset");

   c_write_dac: cover property (@(posedge i_sys_clk) i_reg_wr && i_reg_addr == ARC_OFS_DAC_D_LOW);
   c_read_res: cover property (@(posedge i_sys_clk) i_reg_rd && i_reg_addr == ARC_OFS_IN3_HIGH);
   c_bad_wr: cover property (@(posedge i_sys_clk) i_reg_wr && i_reg_addr == ARC_OFS_IN4_HIGH);
   c_result_load: cover property (@(posedge i_sys_clk) i_result_valid);
   c_read_dac_c: cover property (@(posedge i_sys_clk)
      i_reg_rd && i_reg_addr == ARC_OFS_DAC_C_HIGH);
endmodule : arc_regs

//--- tb/arc_host.sv
/*
 File: host controller model driving the register strobes.
 Assumes: bench calls access and idle on falling edges of i_sys_clk.
*/
`timescale 1ns/1ps
module arc_host (
   // Clock
   input  wire logic       i_sys_clk,
   // Register port
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic [7:0]      o_reg_addr,
   output logic [7:0]      o_reg_wdata
);
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = 8'h00;
      o_reg_wdata = 8'h00;
   end
   // One strobe cycle; back to back calls keep strobes up
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      o_reg_wr    = wr;
      o_reg_rd    = ~wr;
      o_reg_addr  = a;
      o_reg_wdata = d;
      @(negedge i_sys_clk);
   endtask : access
   // Released lines show inverted values
   task automatic idle();
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = ~o_reg_addr;
      o_reg_wdata = ~o_reg_wdata;
      @(negedge i_sys_clk);
   endtask : idle
endmodule : arc_host

//--- tb/tb_arc_regs.sv
/*
 File: self-checking bench for the register slice.
 Assumes: default 12-bit DAC codes, host model on the register port.
*/
`timescale 1ns/1ps
module tb_arc_regs;
   import arc_pkg::*;
   logic        i_sys_clk, i_sys_rst, rvalid, rd_seen, wr, rd;
   logic [9:0]  in3, in4;
   logic [7:0]  oth, addr, wdata, rdata, d;
   logic [11:0] dac [4];
   logic [7:0]  shadow [32];
   logic [7:0]  exp_q [$];
   int          fails, n_tests, cyc, seed;
   arc_host host_u (.i_sys_clk(i_sys_clk), .o_reg_wr(wr), .o_reg_rd(rd),
                    .o_reg_addr(addr), .o_reg_wdata(wdata));
   arc_regs #(.DAC_BITS(12)) dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_result_valid(rvalid), .i_analog_input_third(in3),
      .i_analog_input_fourth(in4), .i_shared_low_other(oth),
      .o_dac_output_a(dac[0]), .o_dac_output_b(dac[1]),
      .o_dac_output_c(dac[2]), .o_dac_output_d(dac[3]));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %0t read %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic chk_dac();
      for (int i = 0; i < 4; i++) begin
         n_tests++;
         if (dac[i] !== {shadow[17+2*i], shadow[16+2*i][7:4]}) begin
            fails++;
            $display("unexpected %0t code %0d is %h", $time, i, dac[i]);
         end
      end
   endtask : chk_dac
   task automatic end_of_test();
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   always @(posedge i_sys_clk) rd_seen <= rd;
   always @(negedge i_sys_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("unexpected %0t read with no expectation", $time);
         end else cmp8(rdata, exp_q.pop_front());
      end
   end
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         $display("unexpected %0t timeout", $time);
         end_of_test();
      end
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      if (a >= ARC_OFS_DAC_A_LOW && a <= ARC_OFS_DAC_D_HIGH)
         shadow[a[4:0]] = a[0] ? v : (v & 8'hF0);
      host_u.access(1'b1, a, v);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      exp_q.push_back(a < 8'h20 ? shadow[a[4:0]] : 8'h00);
      host_u.access(1'b0, a, 8'h00);
   endtask : rd_reg
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      i_sys_rst = 1'b1;
      rvalid = 1'b0;
      in3 = 10'h000;
      in4 = 10'h000;
      oth = 8'h00;
      seed = 85;
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (16) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_sys_rst = 1'b0;
      chk_dac();
      for (int a = 0; a < 8'h18; a++) rd_reg(a[7:0]);
      host_u.idle();
      in3 = 10'($random(seed));
      in4 = 10'($random(seed));
      oth = 8'($random(seed));
      rvalid = 1'b1;
      shadow[10] = in3[9:2];
      shadow[11] = in4[9:2];
      shadow[4] = {in4[1:0], in3[1:0], oth[3:0]};
      @(negedge i_sys_clk);
      rvalid = 1'b0;
      for (int k = 0; k < 3; k++) begin
         d = 8'($random(seed));
         wr_reg(k == 0 ? ARC_OFS_SHARED_LOW : 8'h09 + k[7:0], d);
         rd_reg(k == 0 ? ARC_OFS_SHARED_LOW : 8'h09 + k[7:0]);
      end
      wr_reg(8'h20, 8'hFF);
      rd_reg(8'h20);
      repeat (3) begin
         for (int a = 8'h10; a < 8'h18; a++) begin
            wr_reg(a[7:0], 8'($random(seed)));
            rd_reg(a[7:0]);
         end
         host_u.idle();
         chk_dac();
      end
      i_sys_rst = 1'b1;
      @(negedge i_sys_clk);
      i_sys_rst = 1'b0;
      foreach (shadow[i]) shadow[i] = 8'h00;
      chk_dac();
      rd_reg(ARC_OFS_DAC_C_HIGH);
      host_u.idle();
      repeat (2) @(negedge i_sys_clk);
      end_of_test();
   end
endmodule : tb_arc_regs
